// *** include/modbus_defs.vh ***
`ifndef MODBUS_DEFS_VH
`define MODBUS_DEFS_VH

// Function codes and exception codes
`define FC_READ_HOLD     8'h03
`define FC_READ_INPUT    8'h04
`define FC_WRITE_ONE     8'h06
`define FC_WRITE_BLOCK   8'h10
`define FC_EXC_FLAG      8'h80
`define EXC_BAD_FUNC     8'h01
`define EXC_BAD_ADDR     8'h02
`define EXC_BAD_VALUE    8'h03
`define BROADCAST_ADDR   8'h00

// Register count limits
`define COUNT_ZERO       16'h0000
`define COUNT_ONE        16'h0001
`define READ_MAX_COUNT   16'h007D
`define WRITE_MAX_COUNT  16'h007B

// CRC-16
`define CRC_INIT         16'hFFFF
`define CRC_POLY         16'hA001
`define CRC_RESIDUE      16'h0000

// Request byte offsets
`define OFS_SLAVE        8'h00
`define OFS_FUNC         8'h01
`define OFS_START_HI     8'h02
`define OFS_START_LO     8'h03
`define OFS_COUNT_HI     8'h04
`define OFS_COUNT_LO     8'h05
`define OFS_VALUE_HI     8'h04
`define OFS_BYTE_COUNT   8'h06
`define OFS_BLOCK_DATA   8'h07
`define OFS_STEP         8'h01
`define OFS_WORD_STEP    8'h02

// Packet lengths and indices
`define BUF_DEPTH        9'h100
`define LEN_MIN_REQ      9'h004
`define LEN_FIXED_REQ    9'h008
`define LEN_BLOCK_HDR    9'h009
`define LEN_EXC_BODY     9'h003
`define LEN_ECHO_BODY    9'h006
`define LEN_READ_HDR     9'h003
`define IDX_ZERO         9'h000
`define IDX_STEP         9'h001
`define IDX_FC           9'h001
`define IDX_BYTE_COUNT   9'h002
`define ADDR_STEP        16'h0001
`define LEFT_ONE         8'h01

// Response kinds
`define KIND_EXC         2'h0
`define KIND_ECHO        2'h1
`define KIND_READ        2'h2

// Default register map windows
`define HOLD_FIRST_DEF   16'h0000
`define HOLD_NUM_DEF     17'h00004
`define INPUT_FIRST_DEF  16'h0000
`define INPUT_NUM_DEF    17'h00009

`endif

// *** hdl/crc16_unit.v ***
`timescale 1ns/1ps
`include "modbus_defs.vh"

module crc16_unit (
   input  wire [15:0] crc_in,
   input  wire [7:0]  data_in,
   output reg  [15:0] crc_out
);

   integer i;

   // One byte of reflected CRC-16, bit by bit
   always @* begin
      crc_out = crc_in ^ {8'h00, data_in};
      for (i = 0; i < 8; i = i + 1) begin
         if (crc_out[0]) begin
            crc_out = (crc_out >> 1) ^ `CRC_POLY;
         end else begin
            crc_out = crc_out >> 1;
         end
      end
   end

endmodule // crc16_unit

// *** hdl/modbus_register_access_handler.v ***
`timescale 1ns/1ps
`include "modbus_defs.vh"

// Functional notes
// RULE_01 - Holding read: addr, 0x03, start, count, CRC
// RULE_02 - Input read: same fields, code 0x04
// RULE_03 - Address fields are zero-based register numbers
// RULE_04 - Read count 1..0x7D else exception 3
// RULE_05 - Holding read block must be valid, else 2
// RULE_06 - Input read block must be valid, else 2
// RULE_07 - Count check precedes address check
// RULE_08 - Holding response: count byte, words ascending, CRC
// RULE_09 - Input response: count byte, words ascending, CRC
// RULE_10 - Single write: addr, 0x06, address, value, CRC
// RULE_11 - Single write address invalid gives exception 2
// RULE_12 - Valid single write stores, echoes request
// RULE_13 - Block write: start, count, byte count, values
// RULE_14 - Block write count 1..0x7B else exception 3
// RULE_15 - Invalid block write gives 2, writes nothing
// RULE_16 - Block write stores all, replies header only
// RULE_17 - Exception: addr, code plus 0x80, code, CRC
// RULE_18 - Fields MSB first, CRC LSB first
// RULE_19 - Broadcast executes silently; other addresses ignored
// RULE_20 - Parity or CRC error: discard silently
// RULE_21 - CRC-16 poly 0xA001, init 0xFFFF
// RULE_22 - Valid register windows are configurable parameters
module modbus_register_access_handler #(
   parameter [15:0] HOLD_FIRST  = `HOLD_FIRST_DEF,
   parameter [16:0] HOLD_NUM    = `HOLD_NUM_DEF,
   parameter [15:0] INPUT_FIRST = `INPUT_FIRST_DEF,
   parameter [16:0] INPUT_NUM   = `INPUT_NUM_DEF
) (
   input  wire        clk,
   input  wire        reset_n,
   input  wire [7:0]  own_addr,
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire        rx_parity_err,
   input  wire        rx_frame_end,
   input  wire        tx_ready,
   input  wire [15:0] reg_rdata,
   output wire        tx_valid,
   output wire [7:0]  tx_data,
   output wire        tx_last,
   output wire        reg_rd,
   output wire        reg_wr,
   output wire        reg_input_space,
   output wire [15:0] reg_addr,
   output wire [15:0] reg_wdata
);

   localparam [7:0] S_RECV  = 8'h01;
   localparam [7:0] S_CHECK = 8'h02;
   localparam [7:0] S_WRITE = 8'h04;
   localparam [7:0] S_LOAD  = 8'h08;
   localparam [7:0] S_TX    = 8'h10;
   localparam [7:0] S_RD    = 8'h20;
   localparam [7:0] S_RDW   = 8'h40;
   localparam [7:0] S_CAP   = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // State
   reg  [7:0]  rx_buf [0:255];
   reg  [7:0]  state_ff;
   reg  [8:0]  rx_cnt_ff;
   reg  [15:0] rx_crc_ff;
   reg         rx_bad_ff;
   reg  [1:0]  kind_ff;
   reg  [7:0]  exc_code_ff;
   reg  [8:0]  resp_len_ff;
   reg         respond_ff;
   reg  [8:0]  tx_idx_ff;
   reg  [15:0] tx_crc_ff;
   reg  [15:0] word_ff;
   reg  [15:0] ptr_ff;
   reg  [7:0]  left_ff;
   reg  [7:0]  data_ofs_ff;
   reg         tx_valid_ff;
   reg  [7:0]  tx_data_ff;
   reg         tx_last_ff;
   reg         reg_rd_ff;
   reg         reg_wr_ff;
   reg         reg_input_space_ff;
   reg  [15:0] reg_addr_ff;
   reg  [15:0] reg_wdata_ff;

   wire [15:0] rx_crc_nxt;
   wire [15:0] tx_crc_nxt;
   reg  [7:0]  tx_byte;
   reg  [7:0]  out_byte;
   reg         chk_discard;
   reg         chk_exc;
   reg  [7:0]  chk_code;

   assign tx_valid        = tx_valid_ff;
   assign tx_data         = tx_data_ff;
   assign tx_last         = tx_last_ff;
   assign reg_rd          = reg_rd_ff;
   assign reg_wr          = reg_wr_ff;
   assign reg_input_space = reg_input_space_ff;
   assign reg_addr        = reg_addr_ff;
   assign reg_wdata       = reg_wdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Request fields
   wire [7:0]  slave     = rx_buf[`OFS_SLAVE];
   wire [7:0]  fc        = rx_buf[`OFS_FUNC];
   wire [15:0] start     = {rx_buf[`OFS_START_HI], rx_buf[`OFS_START_LO]};  // [RULE_01] [RULE_18]
   wire [15:0] count16   = {rx_buf[`OFS_COUNT_HI], rx_buf[`OFS_COUNT_LO]};
   wire [7:0]  bytecnt   = rx_buf[`OFS_BYTE_COUNT];
   wire        broadcast = (slave == `BROADCAST_ADDR);
   wire        addr_hit  = (slave == own_addr) || broadcast;                 // [RULE_19]
   wire        frame_ok  = !rx_bad_ff && (rx_crc_ff == `CRC_RESIDUE) &&
                           (rx_cnt_ff >= `LEN_MIN_REQ);                      // [RULE_20] [RULE_21]
   wire [8:0]  read_len  = `LEN_READ_HDR + {count16[7:0], 1'b0};
   wire [8:0]  blk_len   = `LEN_BLOCK_HDR + {1'b0, bytecnt};
   wire [8:0]  idx_nxt   = tx_idx_ff + `IDX_STEP;
   wire [8:0]  crc_hi_ix = resp_len_ff + `IDX_STEP;
   wire [8:0]  rd_bytes  = resp_len_ff - `LEN_READ_HDR;

   // Whole block inside a configured window, no wrap past 0xFFFF
   function in_block;
      input [15:0] first_addr;
      input [15:0] n;
      input [15:0] win_first;
      input [16:0] win_num;
      reg   [16:0] blk_end;
      begin
         blk_end  = {1'b0, first_addr} + {1'b0, n};
         in_block = (first_addr >= win_first) && (blk_end <= ({1'b0, win_first} + win_num));  // [RULE_22] [RULE_03]
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // CRC engines
   crc16_unit u_rx_crc (
      .crc_in  (rx_crc_ff),
      .data_in (rx_data),
      .crc_out (rx_crc_nxt)
   );

   crc16_unit u_tx_crc (
      .crc_in  (tx_crc_ff),
      .data_in (tx_byte),
      .crc_out (tx_crc_nxt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Request checks
   always @* begin
      chk_discard = 1'b0;
      chk_exc     = 1'b0;
      chk_code    = `EXC_BAD_FUNC;
      if (!frame_ok || !addr_hit) begin
         chk_discard = 1'b1;                                                  // [RULE_19] [RULE_20]
      end else begin
         case (fc)
            `FC_READ_HOLD, `FC_READ_INPUT: begin                              // [RULE_01] [RULE_02]
               if (rx_cnt_ff != `LEN_FIXED_REQ) begin
                  chk_discard = 1'b1;
               end else if ((count16 == `COUNT_ZERO) || (count16 > `READ_MAX_COUNT)) begin
                  chk_exc  = 1'b1;                                            // [RULE_04] [RULE_07]
                  chk_code = `EXC_BAD_VALUE;
               end else if (fc == `FC_READ_HOLD) begin
                  if (!in_block(start, count16, HOLD_FIRST, HOLD_NUM)) begin
                     chk_exc  = 1'b1;                                         // [RULE_05]
                     chk_code = `EXC_BAD_ADDR;
                  end
               end else if (!in_block(start, count16, INPUT_FIRST, INPUT_NUM)) begin
                  chk_exc  = 1'b1;                                            // [RULE_06]
                  chk_code = `EXC_BAD_ADDR;
               end
            end
            `FC_WRITE_ONE: begin                                              // [RULE_10]
               if (rx_cnt_ff != `LEN_FIXED_REQ) begin
                  chk_discard = 1'b1;
               end else if (!in_block(start, `COUNT_ONE, HOLD_FIRST, HOLD_NUM)) begin
                  chk_exc  = 1'b1;                                            // [RULE_11]
                  chk_code = `EXC_BAD_ADDR;
               end
            end
            `FC_WRITE_BLOCK: begin                                            // [RULE_13]
               if (rx_cnt_ff < `LEN_BLOCK_HDR) begin
                  chk_discard = 1'b1;
               end else if ((count16 == `COUNT_ZERO) || (count16 > `WRITE_MAX_COUNT) ||
                            (bytecnt != {count16[6:0], 1'b0}) || (rx_cnt_ff != blk_len)) begin
                  chk_exc  = 1'b1;                                            // [RULE_14] [RULE_07]
                  chk_code = `EXC_BAD_VALUE;
               end else if (!in_block(start, count16, HOLD_FIRST, HOLD_NUM)) begin
                  chk_exc  = 1'b1;                                            // [RULE_15]
                  chk_code = `EXC_BAD_ADDR;
               end
            end
            default: begin
               chk_exc  = 1'b1;
               chk_code = `EXC_BAD_FUNC;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response byte selection
   always @* begin
      tx_byte = slave;
      case (kind_ff)
         `KIND_EXC: begin
            if (tx_idx_ff == `IDX_FC) begin
               tx_byte = fc | `FC_EXC_FLAG;                                   // [RULE_17]
            end else if (tx_idx_ff != `IDX_ZERO) begin
               tx_byte = exc_code_ff;
            end
         end
         `KIND_ECHO: begin
            tx_byte = rx_buf[tx_idx_ff[7:0]];                                 // [RULE_12] [RULE_16]
         end
         default: begin
            if (tx_idx_ff == `IDX_FC) begin
               tx_byte = fc;                                                  // [RULE_08] [RULE_09]
            end else if (tx_idx_ff == `IDX_BYTE_COUNT) begin
               tx_byte = rd_bytes[7:0];
            end else if (tx_idx_ff != `IDX_ZERO) begin
               tx_byte = tx_idx_ff[0] ? word_ff[15:8] : word_ff[7:0];         // [RULE_18]
            end
         end
      endcase
      out_byte = tx_byte;
      if (tx_idx_ff == resp_len_ff) begin
         out_byte = tx_crc_ff[7:0];                                           // [RULE_18]
      end else if (tx_idx_ff == crc_hi_ix) begin
         out_byte = tx_crc_ff[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer
   always @(posedge clk) begin
      if ((state_ff == S_RECV) && rx_valid && (rx_cnt_ff < `BUF_DEPTH)) begin
         rx_buf[rx_cnt_ff[7:0]] <= rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff           <= S_RECV;
         rx_cnt_ff          <= `IDX_ZERO;
         rx_crc_ff          <= `CRC_INIT;
         rx_bad_ff          <= 1'b0;
         kind_ff            <= `KIND_EXC;
         exc_code_ff        <= `EXC_BAD_FUNC;
         resp_len_ff        <= `LEN_EXC_BODY;
         respond_ff         <= 1'b0;
         tx_idx_ff          <= `IDX_ZERO;
         tx_crc_ff          <= `CRC_INIT;
         word_ff            <= `COUNT_ZERO;
         ptr_ff             <= `COUNT_ZERO;
         left_ff            <= `LEFT_ONE;
         data_ofs_ff        <= `OFS_BLOCK_DATA;
         tx_valid_ff        <= 1'b0;
         tx_data_ff         <= `BROADCAST_ADDR;
         tx_last_ff         <= 1'b0;
         reg_rd_ff          <= 1'b0;
         reg_wr_ff          <= 1'b0;
         reg_input_space_ff <= 1'b0;
         reg_addr_ff        <= `COUNT_ZERO;
         reg_wdata_ff       <= `COUNT_ZERO;
      end else begin
         reg_rd_ff <= 1'b0;
         reg_wr_ff <= 1'b0;
         case (state_ff)
            S_RECV: begin
               if (rx_valid) begin
                  if (rx_cnt_ff < `BUF_DEPTH) begin
                     rx_cnt_ff <= rx_cnt_ff + `IDX_STEP;
                     rx_crc_ff <= rx_crc_nxt;                                 // [RULE_21]
                  end else begin
                     rx_bad_ff <= 1'b1;
                  end
                  if (rx_parity_err) begin
                     rx_bad_ff <= 1'b1;                                       // [RULE_20]
                  end
               end
               if (rx_frame_end && (rx_valid || (rx_cnt_ff != `IDX_ZERO))) begin
                  state_ff <= S_CHECK;
               end
            end
            S_CHECK: begin
               rx_cnt_ff   <= `IDX_ZERO;
               rx_crc_ff   <= `CRC_INIT;
               rx_bad_ff   <= 1'b0;
               respond_ff  <= !broadcast;                                     // [RULE_19]
               tx_idx_ff   <= `IDX_ZERO;
               tx_crc_ff   <= `CRC_INIT;
               ptr_ff      <= start;                                          // [RULE_03]
               exc_code_ff <= chk_code;
               if (chk_discard) begin
                  state_ff <= S_RECV;
               end else if (chk_exc) begin
                  kind_ff     <= `KIND_EXC;                                   // [RULE_17]
                  resp_len_ff <= `LEN_EXC_BODY;
                  state_ff    <= broadcast ? S_RECV : S_LOAD;
               end else if ((fc == `FC_READ_HOLD) || (fc == `FC_READ_INPUT)) begin
                  kind_ff     <= `KIND_READ;                                  // [RULE_08] [RULE_09]
                  resp_len_ff <= read_len;
                  state_ff    <= broadcast ? S_RECV : S_LOAD;
               end else if (fc == `FC_WRITE_ONE) begin
                  kind_ff     <= `KIND_ECHO;                                  // [RULE_12]
                  resp_len_ff <= `LEN_ECHO_BODY;
                  left_ff     <= `LEFT_ONE;
                  data_ofs_ff <= `OFS_VALUE_HI;
                  state_ff    <= S_WRITE;
               end else begin
                  kind_ff     <= `KIND_ECHO;                                  // [RULE_16]
                  resp_len_ff <= `LEN_ECHO_BODY;
                  left_ff     <= count16[7:0];
                  data_ofs_ff <= `OFS_BLOCK_DATA;
                  state_ff    <= S_WRITE;
               end
            end
            S_WRITE: begin
               reg_wr_ff          <= 1'b1;                                    // [RULE_12] [RULE_16]
               reg_input_space_ff <= 1'b0;
               reg_addr_ff        <= ptr_ff;
               reg_wdata_ff       <= {rx_buf[data_ofs_ff], rx_buf[data_ofs_ff + `OFS_STEP]};  // [RULE_18]
               ptr_ff             <= ptr_ff + `ADDR_STEP;
               data_ofs_ff        <= data_ofs_ff + `OFS_WORD_STEP;
               left_ff            <= left_ff - `LEFT_ONE;
               if (left_ff == `LEFT_ONE) begin
                  state_ff <= respond_ff ? S_LOAD : S_RECV;                   // [RULE_19]
               end
            end
            S_LOAD: begin
               tx_valid_ff <= 1'b1;
               tx_data_ff  <= out_byte;
               tx_last_ff  <= (tx_idx_ff == crc_hi_ix);
               if (tx_idx_ff < resp_len_ff) begin
                  tx_crc_ff <= tx_crc_nxt;                                    // [RULE_21]
               end
               state_ff <= S_TX;
            end
            S_TX: begin
               if (tx_ready) begin
                  tx_valid_ff <= 1'b0;
                  tx_last_ff  <= 1'b0;
                  tx_idx_ff   <= idx_nxt;
                  if (tx_last_ff) begin
                     state_ff <= S_RECV;
                  end else if ((kind_ff == `KIND_READ) && idx_nxt[0] &&
                               (idx_nxt >= `LEN_READ_HDR) && (idx_nxt < resp_len_ff)) begin
                     state_ff <= S_RD;
                  end else begin
                     state_ff <= S_LOAD;
                  end
               end
            end
            S_RD: begin
               reg_rd_ff          <= 1'b1;                                    // [RULE_08] [RULE_09]
               reg_input_space_ff <= (fc == `FC_READ_INPUT);
               reg_addr_ff        <= ptr_ff;
               ptr_ff             <= ptr_ff + `ADDR_STEP;
               state_ff           <= S_RDW;
            end
            S_RDW: begin
               state_ff <= S_CAP;
            end
            S_CAP: begin
               word_ff  <= reg_rdata;
               state_ff <= S_LOAD;
            end
            default: begin
               state_ff <= S_RECV;
            end
         endcase
      end
   end

endmodule // modbus_register_access_handler

// *** dv/modbus_handler_checker.sv ***
`timescale 1ns/1ps
module modbus_handler_checker #(
   parameter [15:0] HOLD_FIRST  = 16'h0000,
   parameter [16:0] HOLD_NUM    = 17'h00004,
   parameter [15:0] INPUT_FIRST = 16'h0000,
   parameter [16:0] INPUT_NUM   = 17'h00009
) (
   input wire        clk,
   input wire        reset_n,
   input wire        tx_valid,
   input wire        tx_ready,
   input wire [7:0]  tx_data,
   input wire        tx_last,
   input wire        reg_rd,
   input wire        reg_wr,
   input wire        reg_input_space,
   input wire [15:0] reg_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [16:0] addr_x = {1'b0, reg_addr};
   ////////////////////////////////////////////////////////////////////////////
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("tx byte changed before accept");
   a_last_ends: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*4])
      else $error("tx continued after last byte");
   a_rd_pulse: assert property (reg_rd |=> !reg_rd [*2])
      else $error("register reads too close");
   a_rw_apart: assert property (!(reg_rd && reg_wr))
      else $error("read and write strobes together");
   a_wr_ascend: assert property (reg_wr && $past(reg_wr) |-> reg_addr == $past(reg_addr) + 16'h0001)
      else $error("block write not ascending");
   a_wr_before_tx: assert property (tx_valid |-> !reg_wr)
      else $error("write during response");
   a_wr_window: assert property (reg_wr |-> !reg_input_space && reg_addr >= HOLD_FIRST
                                 && addr_x < {1'b0, HOLD_FIRST} + HOLD_NUM)
      else $error("write outside holding window");
   a_rd_window: assert property (reg_rd |-> (reg_input_space
      ? (reg_addr >= INPUT_FIRST && addr_x < {1'b0, INPUT_FIRST} + INPUT_NUM)
      : (reg_addr >= HOLD_FIRST && addr_x < {1'b0, HOLD_FIRST} + HOLD_NUM)))
      else $error("read outside register window");
endmodule // modbus_handler_checker

bind modbus_register_access_handler modbus_handler_checker #(
   .HOLD_FIRST(HOLD_FIRST), .HOLD_NUM(HOLD_NUM), .INPUT_FIRST(INPUT_FIRST), .INPUT_NUM(INPUT_NUM)
) i_chk (
   .clk(clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
   .tx_last(tx_last), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_input_space(reg_input_space), .reg_addr(reg_addr)
);

// *** dv/reg_map_model.sv ***
`timescale 1ns/1ps
module reg_map_model (
   input  wire        clk,
   input  wire        reg_rd,
   input  wire        reg_wr,
   input  wire        reg_input_space,
   input  wire [15:0] reg_addr,
   input  wire [15:0] reg_wdata,
   output logic [15:0] reg_rdata
);
   logic [15:0] hold_mem [0:3];
   initial begin
      reg_rdata = 16'h0000;
      for (int i = 0; i < 4; i++) hold_mem[i] = 16'hA000 + 16'(i);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read data only in the cycle after the strobe, inverted otherwise
   always @(posedge clk) begin
      if (reg_wr && !reg_input_space && reg_addr < 16'h0004)
         hold_mem[reg_addr[1:0]] <= reg_wdata;
      if (reg_rd && reg_input_space && reg_addr < 16'h0009)
         reg_rdata <= 16'hB000 + reg_addr;
      else if (reg_rd && !reg_input_space && reg_addr < 16'h0004)
         reg_rdata <= hold_mem[reg_addr[1:0]];
      else
         reg_rdata <= ~reg_rdata;
   end
endmodule // reg_map_model

// *** dv/modbus_register_access_handler_bench.sv ***
`timescale 1ns/1ps
module modbus_register_access_handler_bench;
   localparam [7:0] OWN_ADDR = 8'h2A;
   logic        clk;
   logic        reset_n;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        rx_parity_err;
   logic        rx_frame_end;
   logic        tx_ready;
   wire  [15:0] reg_rdata;
   wire         tx_valid;
   wire  [7:0]  tx_data;
   wire         tx_last;
   wire         reg_rd;
   wire         reg_wr;
   wire         reg_input_space;
   wire  [15:0] reg_addr;
   wire  [15:0] reg_wdata;
   logic [7:0]  pkt[$];
   logic [7:0]  exp[$];
   logic [7:0]  rsp[$];
   logic [15:0] exp_hold[0:3];
   int          n_errors;
   int          check_count;

   modbus_register_access_handler i_dut (
      .clk(clk), .reset_n(reset_n), .own_addr(OWN_ADDR), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_parity_err(rx_parity_err), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready), .reg_rdata(reg_rdata),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_input_space(reg_input_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   reg_map_model i_map (
      .clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_input_space(reg_input_space),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] want);
      check_count++;
      if (got !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task mk(input logic [7:0] a, input logic [7:0] f, input logic [15:0] p, input logic [15:0] q);
      pkt = '{a, f, p[15:8], p[7:0], q[15:8], q[7:0]};
   endtask
   task send(input bit bad, input bit perr);
      logic [15:0] c;
      c = crc16(pkt) ^ {15'h0000, bad};
      pkt.push_back(c[7:0]);
      pkt.push_back(c[15:8]);
      repeat (2) @(negedge clk);
      foreach (pkt[i]) begin
         rx_valid = 1'b1;
         rx_data = pkt[i];
         rx_parity_err = perr && (i == 2);
         rx_frame_end = (i == pkt.size() - 1);
         @(negedge clk);
      end
      rx_valid = 1'b0;
      rx_frame_end = 1'b0;
      rx_parity_err = 1'b0;
   endtask
   // Collect one reply while stalling every other cycle
   task get_resp;
      bit done;
      done = 1'b0;
      rsp.delete();
      repeat (3000) if (!done) begin
         @(negedge clk);
         tx_ready = ~tx_ready;
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rsp.push_back(tx_data);
            done = (tx_last === 1'b1);
         end
      end
   endtask
   task cmp_resp;
      logic [15:0] c;
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      chk(16'(rsp.size()), 16'(exp.size()));
      foreach (exp[i]) if (i < rsp.size()) chk({8'h00, rsp[i]}, {8'h00, exp[i]});
   endtask
   task quiet;
      logic seen;
      seen = 1'b0;
      repeat (30) begin
         @(negedge clk);
         seen = seen | tx_valid;
      end
      chk({15'h0000, seen}, 16'h0000);
   endtask
   task do_read(input logic [7:0] f, input logic [15:0] s, input logic [15:0] n);
      logic [15:0] w;
      mk(OWN_ADDR, f, s, n);
      send(1'b0, 1'b0);
      get_resp;
      exp = '{OWN_ADDR, f, 8'(2 * n)};
      for (int i = 0; i < n; i++) begin
         w = (f == 8'h03) ? exp_hold[s + 16'(i)] : 16'hB000 + s + 16'(i);
         exp.push_back(w[15:8]);
         exp.push_back(w[7:0]);
      end
      cmp_resp;
   endtask
   task exc(input logic [7:0] f, input logic [15:0] s, input logic [15:0] n, input logic [7:0] code);
      logic [7:0] bc;
      mk(OWN_ADDR, f, s, n);
      if (f == 8'h10) begin
         bc = (n <= 16'h007B) ? 8'(2 * n) : 8'h00;
         pkt.push_back(bc);
         repeat (bc) pkt.push_back(8'h00);
      end
      send(1'b0, 1'b0);
      get_resp;
      exp = '{OWN_ADDR, f | 8'h80, code};
      cmp_resp;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reads;
      do_read(8'h03, 16'h0000, 16'h0001);
      do_read(8'h03, 16'h0001, 16'h0003);
      do_read(8'h04, 16'h0000, 16'h0009);
      do_read(8'h04, 16'h0008, 16'h0001);
   endtask
   task t_exceptions;
      exc(8'h03, 16'h0000, 16'h0000, 8'h03);
      exc(8'h03, 16'h0100, 16'h007E, 8'h03);
      exc(8'h04, 16'h0100, 16'h007E, 8'h03);
      exc(8'h03, 16'h0000, 16'h007D, 8'h02);
      exc(8'h03, 16'h0003, 16'h0002, 8'h02);
      exc(8'h04, 16'h0005, 16'h0005, 8'h02);
      exc(8'h06, 16'h0004, 16'h0007, 8'h02);
      exc(8'h10, 16'h0000, 16'h0000, 8'h03);
      exc(8'h10, 16'h0000, 16'h007C, 8'h03);
      exc(8'h10, 16'h0000, 16'h007B, 8'h02);
      exc(8'h10, 16'h0003, 16'h0002, 8'h02);
      exc(8'h01, 16'h0000, 16'h0001, 8'h01);
      do_read(8'h03, 16'h0000, 16'h0004);
   endtask
   task t_write_one;
      mk(OWN_ADDR, 8'h06, 16'h0002, 16'h1234);
      exp = pkt;
      send(1'b0, 1'b0);
      get_resp;
      cmp_resp;
      exp_hold[2] = 16'h1234;
      do_read(8'h03, 16'h0000, 16'h0004);
   endtask
   task t_write_block;
      mk(OWN_ADDR, 8'h10, 16'h0001, 16'h0003);
      exp = pkt;
      pkt.push_back(8'h06);
      for (int i = 1; i < 4; i++) begin
         exp_hold[i] = 16'h5A00 + 16'(i);
         pkt.push_back(8'h5A);
         pkt.push_back(8'(i));
      end
      send(1'b0, 1'b0);
      get_resp;
      cmp_resp;
      do_read(8'h03, 16'h0000, 16'h0004);
   endtask
   task t_drops;
      mk(8'h00, 8'h06, 16'h0003, 16'h0077);
      send(1'b0, 1'b0);
      quiet;
      exp_hold[3] = 16'h0077;
      mk(OWN_ADDR, 8'h06, 16'h0000, 16'h0BAD);
      send(1'b1, 1'b0);
      quiet;
      mk(OWN_ADDR, 8'h06, 16'h0001, 16'h0BAD);
      send(1'b0, 1'b1);
      quiet;
      mk(8'h2B, 8'h03, 16'h0000, 16'h0001);
      send(1'b0, 1'b0);
      quiet;
      do_read(8'h03, 16'h0000, 16'h0004);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100us;
      n_errors++;
      results;
   end
   initial begin
      reset_n = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_parity_err = 1'b0;
      rx_frame_end = 1'b0;
      tx_ready = 1'b1;
      n_errors = 0;
      check_count = 0;
      for (int i = 0; i < 4; i++) exp_hold[i] = 16'hA000 + 16'(i);
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      t_reads;
      t_exceptions;
      t_write_one;
      t_write_block;
      t_drops;
      results;
   end
endmodule // modbus_register_access_handler_bench
